// ---- inc/lgb_pkg.sv ----
package lgb_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PT_NUM       = 14;
  localparam int unsigned PT_PER_CURVE = 7;

  // Subaddresses
  localparam logic [7:0] OFS_POINT_FIRST = 8'h26;
  localparam logic [7:0] OFS_POINT_LAST  = 8'h33;
  localparam logic [7:0] OFS_AVG_LUMA    = 8'h34;
  localparam logic [7:0] OFS_CLK_CTRL    = 8'h35;

  // Clock pin control fields
  localparam int unsigned CLK_CTRL_EN_BIT = 1;
  localparam logic [7:0]  CLK_CTRL_RESET  = 8'h78;

  // Curve point reset values: point k resets to ((k mod 7) + 1) * step
  localparam logic [7:0] PT_STEP_RESET = 8'h20;

  // Fixed curve points and segment geometry
  localparam logic [7:0]  FIX_LOW      = 8'h10;
  localparam logic [7:0]  FIX_HIGH     = 8'hF0;
  localparam logic [7:0]  PT_POS_FIRST = 8'h20;
  localparam logic [7:0]  PT_POS_LAST  = 8'hE0;
  localparam int unsigned FRAC_W       = 5;
  localparam logic [14:0] FRAC_ROUND   = 15'h0010;

  // Brightness accumulator widths
  localparam int unsigned SUM_W = 32;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned REM_W = 40;
  localparam logic [2:0]  QUO_MSB = 3'h7;

  typedef enum logic {
    DIV_IDLE,
    DIV_RUN
  } lgb_div_st_t;

  typedef struct packed {
    logic [PT_NUM-1:0][7:0] pts;
    logic [7:0]             clk_ctrl;
    logic                   gate;
    logic [7:0]             luma_out;
    logic [7:0]             chroma_out;
    logic                   out_valid;
    logic                   vsync_prev;
    logic [SUM_W-1:0]       sum;
    logic [CNT_W-1:0]       cnt;
    lgb_div_st_t            st;
    logic [REM_W-1:0]       rem;
    logic [CNT_W-1:0]       dcnt;
    logic [2:0]             bit_idx;
    logic [7:0]             quot;
    logic [7:0]             avg;
    logic [7:0]             rdata;
    logic                   rvalid;
  } lgb_state_t;

endpackage : lgb_pkg

// ---- src/lgb_luma_gamma.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Fourteen writable curve point registers 26H-33H
// - Gamma only on luma, chroma unchanged
// - Two curves stored, exactly one applied
// - Programmable points at inputs 32 to 224
// - Linear interpolation between adjacent curve points
// - Points 0, 16, 240, 255 are fixed
// - Read-only field average luma at 34H
// - Only active video samples are averaged
// - Average updated on vertical sync falling edge
// - Bit 1 at 35H enables PLL clock pin
// - Enable needs PLL on and oversampling on
module lgb_luma_gamma (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [7:0] reg_subaddr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       curve_b_select,
  input  wire logic       pll_disable_bit,
  input  wire logic       oversample_enable_bit,
  input  wire logic       pll_clk,
  output logic            pll_clock_pin,
  input  wire logic       vsync,
  input  wire logic       active_video,
  input  wire logic       pix_valid,
  input  wire logic [7:0] luma_in,
  input  wire logic [7:0] chroma_in,
  output logic      [7:0] luma_out,
  output logic      [7:0] chroma_out,
  output logic            pix_valid_out
);

  lgb_pkg::lgb_state_t q;
  lgb_pkg::lgb_state_t d;

  always_comb begin
    logic [7:0]                  x;
    logic [7:0]                  lo;
    logic [7:0]                  hi;
    logic [lgb_pkg::FRAC_W-1:0]  frac;
    logic signed [8:0]           diff;
    logic signed [14:0]          prod;
    logic signed [15:0]          acc;
    logic [7:0]                  yo;
    logic [3:0]                  off;
    logic [3:0]                  seg;
    logic                        take;
    logic [lgb_pkg::SUM_W-1:0]   sum_n;
    logic [lgb_pkg::CNT_W-1:0]   cnt_n;
    logic [lgb_pkg::REM_W-1:0]   trial;
    logic [7:0]                  quot_n;
    logic [7:0]                  sel_addr;
    x        = luma_in;
    lo       = 8'h00;
    hi       = 8'h00;
    frac     = '0;
    diff     = '0;
    prod     = '0;
    acc      = '0;
    yo       = 8'h00;
    off      = 4'h0;
    seg      = 4'h0;
    take     = 1'b0;
    sum_n    = '0;
    cnt_n    = '0;
    trial    = '0;
    quot_n   = 8'h00;
    sel_addr = 8'h00;
    d        = q;

    // Register writes
    if (reg_wr) begin
      for (int k = 0; k < lgb_pkg::PT_NUM; k++) begin
        sel_addr = 8'(lgb_pkg::OFS_POINT_FIRST + k);
        if (reg_subaddr == sel_addr) begin
          d.pts[k] = reg_wdata;
        end
      end
      if (reg_subaddr == lgb_pkg::OFS_CLK_CTRL) begin
        d.clk_ctrl = reg_wdata;
      end
    end

    // Register reads, one cycle after the strobe
    d.rvalid = reg_rd;
    if (reg_rd) begin
      d.rdata = 8'h00;
      if (reg_subaddr >= lgb_pkg::OFS_POINT_FIRST &&
          reg_subaddr <= lgb_pkg::OFS_POINT_LAST) begin
        sel_addr = 8'(reg_subaddr - lgb_pkg::OFS_POINT_FIRST);
        d.rdata  = q.pts[sel_addr[3:0]];
      end else if (reg_subaddr == lgb_pkg::OFS_AVG_LUMA) begin
        d.rdata = q.avg;
      end else if (reg_subaddr == lgb_pkg::OFS_CLK_CTRL) begin
        d.rdata    = q.clk_ctrl;
      end
    end

    // Clock pin gate
    d.gate = q.clk_ctrl[lgb_pkg::CLK_CTRL_EN_BIT] &
             ~pll_disable_bit & oversample_enable_bit;

    // Curve selection: A in the first seven points, B in the last seven
    off = curve_b_select ? 4'(lgb_pkg::PT_PER_CURVE) : 4'h0;

    // Segment lookup and interpolation
    if (x < lgb_pkg::FIX_LOW || x >= lgb_pkg::FIX_HIGH) begin
      yo = x;
    end else begin
      if (x < lgb_pkg::PT_POS_FIRST) begin
        lo   = lgb_pkg::FIX_LOW;
        hi   = q.pts[off];
        frac = {x[3:0], 1'b0};
      end else if (x >= lgb_pkg::PT_POS_LAST) begin
        seg  = 4'(off + 4'(lgb_pkg::PT_PER_CURVE - 1));
        lo   = q.pts[seg];
        hi   = lgb_pkg::FIX_HIGH;
        frac = {x[3:0], 1'b0};
      end else begin
        seg  = 4'(off + {1'b0, x[7:5]} - 4'h1);
        lo   = q.pts[seg];
        hi   = q.pts[4'(seg + 4'h1)];
        frac = x[4:0];
      end
      diff = $signed({1'b0, hi}) - $signed({1'b0, lo});
      prod = diff * $signed({1'b0, frac});
      acc  = $signed({8'h00, lo}) +
             16'((prod + $signed(lgb_pkg::FRAC_ROUND)) >>> lgb_pkg::FRAC_W);
      yo   = acc[7:0];
    end

    // Output stage, chroma carried with the same delay
    d.out_valid = pix_valid;
    if (pix_valid) begin
      d.luma_out   = yo;
      d.chroma_out = chroma_in;
    end

    // Brightness accumulation over active video
    take  = pix_valid & active_video;
    sum_n = q.sum;
    cnt_n = q.cnt;
    if (take) begin
      sum_n = lgb_pkg::SUM_W'(q.sum + {24'h00_0000, luma_in});
      cnt_n = lgb_pkg::CNT_W'(q.cnt + 1'b1);
    end
    d.vsync_prev = vsync;
    d.sum        = sum_n;
    d.cnt        = cnt_n;

    // Serial divider, one quotient bit per cycle
    case (q.st)
      lgb_pkg::DIV_IDLE: begin
        d.st = lgb_pkg::DIV_IDLE;
      end
      lgb_pkg::DIV_RUN: begin
        trial  = {16'h0000, q.dcnt} << q.bit_idx;
        quot_n = q.quot;
        if (q.rem >= trial) begin
          d.rem          = q.rem - trial;
          quot_n[q.bit_idx] = 1'b1;
        end
        d.quot    = quot_n;
        d.bit_idx = 3'(q.bit_idx - 3'h1);
        if (q.bit_idx == 3'h0) begin
          d.avg = quot_n;
          d.st  = lgb_pkg::DIV_IDLE;
        end
      end
      default: begin
        d.st = lgb_pkg::DIV_IDLE;
      end
    endcase

    // Field boundary on vertical sync falling edge
    if (q.vsync_prev && !vsync) begin
      d.rem     = {8'h00, q.sum};
      d.dcnt    = q.cnt;
      d.bit_idx = lgb_pkg::QUO_MSB;
      d.quot    = 8'h00;
      if (q.cnt == '0) begin
        d.avg = 8'h00;
        d.st  = lgb_pkg::DIV_IDLE;
      end else begin
        d.st = lgb_pkg::DIV_RUN;
      end
      d.sum = take ? {24'h00_0000, luma_in} : '0;
      d.cnt = take ? lgb_pkg::CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < lgb_pkg::PT_NUM; k++) begin
        q.pts[k] <= 8'(lgb_pkg::PT_STEP_RESET * ((k % lgb_pkg::PT_PER_CURVE) + 1));
      end
      q.clk_ctrl   <= lgb_pkg::CLK_CTRL_RESET;
      q.gate       <= 1'b0;
      q.luma_out   <= 8'h00;
      q.chroma_out <= 8'h00;
      q.out_valid  <= 1'b0;
      q.vsync_prev <= 1'b0;
      q.sum        <= '0;
      q.cnt        <= '0;
      q.st         <= lgb_pkg::DIV_IDLE;
      q.rem        <= '0;
      q.dcnt       <= '0;
      q.bit_idx    <= 3'h0;
      q.quot       <= 8'h00;
      q.avg        <= 8'h00;
      q.rdata      <= 8'h00;
      q.rvalid     <= 1'b0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata     = q.rdata;
  assign reg_rvalid    = q.rvalid;
  assign luma_out      = q.luma_out;
  assign chroma_out    = q.chroma_out;
  assign pix_valid_out = q.out_valid;
  assign pll_clock_pin = pll_clk & q.gate;

endmodule : lgb_luma_gamma

`default_nettype wire

// ---- sim/lgb_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module lgb_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic [7:0] reg_subaddr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       pll_disable_bit,
  input wire logic       oversample_enable_bit,
  input wire logic       pll_clock_pin,
  input wire logic       pix_valid,
  input wire logic [7:0] luma_in,
  input wire logic [7:0] chroma_in,
  input wire logic [7:0] luma_out,
  input wire logic [7:0] chroma_out,
  input wire logic       pix_valid_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd; ce && reg_rd; endsequence
  sequence s_px; ce && pix_valid; endsequence
  AST_RD_ANS: assert property (s_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_RD_ONE: assert property (ce && !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("stray read answer");
  AST_UNMAP: assert property (s_rd ##0 (reg_subaddr < 8'h26 || reg_subaddr > 8'h35)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_PIX_LAT: assert property (s_px |=> pix_valid_out)
    else $error("sample lost");
  AST_CHROMA: assert property (s_px |=> chroma_out == $past(chroma_in))
    else $error("chroma altered");
  AST_LOW_ID: assert property (s_px ##0 luma_in < 8'h10 |=> luma_out == $past(luma_in))
    else $error("low end point moved");
  AST_HIGH_ID: assert property (s_px ##0 luma_in >= 8'hF0 |=> luma_out == $past(luma_in))
    else $error("high end point moved");
  AST_PLL_OFF: assert property (ce && pll_disable_bit |=> !pll_clock_pin)
    else $error("clock pin with pll off");
  AST_OVS_OFF: assert property (ce && !oversample_enable_bit |=> !pll_clock_pin)
    else $error("clock pin without oversampling");
endmodule : lgb_props
bind lgb_luma_gamma lgb_props u_props (.clk(clk), .nrst(nrst), .ce(ce),
  .reg_subaddr(reg_subaddr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pll_disable_bit(pll_disable_bit), .oversample_enable_bit(oversample_enable_bit),
  .pll_clock_pin(pll_clock_pin), .pix_valid(pix_valid), .luma_in(luma_in),
  .chroma_in(chroma_in), .luma_out(luma_out), .chroma_out(chroma_out),
  .pix_valid_out(pix_valid_out));
`default_nettype wire

// ---- sim/lgb_pix_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module lgb_pix_src (
  input  wire logic       clk,
  input  wire logic       run,
  output logic            pv,
  output logic            act,
  output logic      [7:0] y,
  output logic      [7:0] c
);
  initial begin
    pv = 1'b0;
    act = 1'b0;
    y = 8'h00;
    c = 8'h00;
  end
  // Idle data lines toggle so stale samples never look valid
  always @(negedge clk) begin
    pv = run && ($urandom_range(3) != 0);
    act = $urandom_range(1) != 0;
    y = run ? 8'($urandom) : ~y;
    c = run ? 8'($urandom) : ~c;
  end
endmodule : lgb_pix_src
`default_nettype wire

// ---- sim/lgb_luma_gamma_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lgb_luma_gamma_tb;
  logic       clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, cb = 0, pdis = 0, ovs = 0;
  logic       pll = 0, vs = 1, run = 0, rv, pin, pv, act, pvo, pend, vp;
  logic [7:0] sa = 0, wd = 0, rdata, yo, co, y, c;
  int         err_total = 0, total_checks = 0, pts[14], sum, cnt, avg_e, ye, ce_e;
  always #2.5 clk = ~clk;
  // Offset keeps pll edges away from the clk edges at which the pin is checked
  initial #0.1 forever #9.2 pll = ~pll;
  lgb_pix_src src (.clk(clk), .run(run), .pv(pv), .act(act), .y(y), .c(c));
  lgb_luma_gamma uut (.clk(clk), .nrst(nrst), .ce(ce), .reg_subaddr(sa), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdata), .reg_rvalid(rv), .curve_b_select(cb),
    .pll_disable_bit(pdis), .oversample_enable_bit(ovs), .pll_clk(pll), .pll_clock_pin(pin),
    .vsync(vs), .active_video(act), .pix_valid(pv), .luma_in(y), .chroma_in(c),
    .luma_out(yo), .chroma_out(co), .pix_valid_out(pvo));
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  function int gam(int x);
    int q[9];
    int s;
    int f;
    q[0] = 16;
    q[8] = 240;
    for (int i = 1; i < 8; i++) q[i] = pts[i - 1 + (cb ? 7 : 0)];
    if (x < 16 || x >= 240) return x;
    s = x < 32 ? 0 : (x >= 224 ? 7 : x / 32);
    f = (x < 32 || x >= 224) ? (x % 16) * 2 : x % 32;
    return q[s] + (((q[s + 1] - q[s]) * f + 16) >>> 5);
  endfunction : gam
  always @(posedge clk) begin
    if (!nrst) begin
      pend = 0;
      vp = 0;
      sum = 0;
      cnt = 0;
    end else begin
      chk(pvo, pend);
      if (pend) chk(yo, ye[7:0]);
      if (pend) chk(co, ce_e[7:0]);
      if (ce) begin
        pend = pv;
        ye = gam(y);
        ce_e = c;
        if (vp && !vs) avg_e = cnt ? sum / cnt : 0;
        if (vp && !vs) {sum, cnt} = 0;
        vp = vs;
        if (pv && act) sum += y;
        if (pv && act) cnt++;
      end
    end
  end
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {sa, wd, wr} = {a, d, 1'b1};
    @(negedge clk) wr = 0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) {sa, rd} = {a, 1'b1};
    @(negedge clk) rd = 0;
    chk(rv, 1);
    chk(rdata, e);
  endtask : rd_reg
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task end_sim;
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(74149));
    for (int k = 0; k < 14; k++) pts[k] = 32 * (k % 7 + 1);
    idle(10);
    nrst = 1;
    for (int k = 0; k < 14; k++) rd_reg(8'(8'h26 + k), 8'(pts[k]));
    rd_reg(8'h35, 8'h78);
    rd_reg(8'h40, 8'h00);
    for (int k = 0; k < 14; k++) pts[k] = $urandom_range(240, 16);
    for (int k = 0; k < 14; k++) wr_reg(8'(8'h26 + k), 8'(pts[k]));
    for (int k = 0; k < 14; k++) rd_reg(8'(8'h26 + k), 8'(pts[k]));
    for (int b = 0; b < 2; b++) begin
      cb = b[0];
      run = 1;
      idle(150);
      ce = 0;
      idle(3);
      ce = 1;
      idle(150);
      run = 0;
      idle(2);
    end
    for (int f = 0; f < 2; f++) begin
      vs = 0;
      idle(10);
      wr_reg(8'h34, 8'hAA);
      rd_reg(8'h34, 8'(avg_e));
      vs = 1;
      idle(2);
    end
    wr_reg(8'h35, 8'h7A);
    rd_reg(8'h35, 8'h7A);
    for (int m = 0; m < 4; m++) begin
      {pdis, ovs} = 2'(m);
      idle(2);
      repeat (6) @(negedge clk) chk(pin, pll & !pdis & ovs);
    end
    wr_reg(8'h35, 8'h78);
    rd_reg(8'h35, 8'h78);
    {pdis, ovs} = 2'b01;
    idle(2);
    repeat (6) @(negedge clk) chk(pin, 1'b0);
    end_sim;
  end
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
endmodule : lgb_luma_gamma_tb
`default_nettype wire
